// File: hdl/srs_pkg.sv
// package of constants and types for the status reporting block
`default_nettype none
package srs_pkg;
  // ==========================================================================
  // register byte offsets on the apb bus
  localparam logic [7:0] REG_CMD      = 8'h00;
  localparam logic [7:0] REG_REPLY    = 8'h04;
  localparam logic [7:0] REG_SRE      = 8'h08;
  localparam logic [7:0] REG_ESE      = 8'h0c;
  localparam logic [7:0] REG_ESR      = 8'h10;
  localparam logic [7:0] REG_STB      = 8'h14;
  localparam logic [7:0] REG_IRQ_STAT = 8'h18;
  localparam logic [7:0] REG_IRQ_MASK = 8'h1c;

  // ==========================================================================
  // command word layout: opcode in the low nibble, argument above
  localparam int OP_LSB  = 0;
  localparam int OP_W    = 4;
  localparam int ARG_LSB = 8;
  localparam int ARG_W   = 16;

  typedef enum logic [3:0] {
    OP_NOP   = 4'h0,
    OP_SRE   = 4'h1,
    OP_SRE_Q = 4'h2,
    OP_STB_Q = 4'h3,
    OP_ESE   = 4'h4,
    OP_ESE_Q = 4'h5,
    OP_ESR_Q = 4'h6,
    OP_CLS   = 4'h7,
    OP_OPC   = 4'h8,
    OP_OPC_Q = 4'h9
  } srs_op_t;

  // ==========================================================================
  // status byte bit positions
  localparam int STB_ERRQ = 2;
  localparam int STB_QUES = 3;
  localparam int STB_MAV  = 4;
  localparam int STB_ESB  = 5;
  localparam int STB_MSS  = 6;

  // standard event register bit positions and implemented bits
  localparam int ESR_OPC  = 0;
  localparam int ESR_EXE  = 4;
  localparam logic [7:0] ESR_USED  = 8'hbd;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] OPC_REPLY = 8'h01;

  // interrupt status bits
  localparam int IRQ_SRQ = 0;
  localparam int IRQ_RNG = 1;
  localparam int IRQ_OPC = 2;
  localparam int IRQ_W   = 3;

  // ==========================================================================
  // reply word handed to the output queue
  typedef struct packed {
    logic       vld;
    logic [7:0] data;
  } srs_reply_t;

  // level inputs that feed the status byte
  typedef struct packed {
    logic errq;
    logic ques;
    logic mav;
  } srs_sum_t;

  // complete state of the top module
  typedef struct packed {
    logic [7:0]       sre;
    logic [7:0]       ese;
    logic [7:0]       esr;
    logic             opc_pend;
    logic             opcq_pend;
    srs_reply_t       reply;
    logic             cls_pulse;
    logic             mss_q;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [31:0]      prdata;
    logic             pslverr;
  } srs_state_t;
endpackage : srs_pkg
`default_nettype wire

// File: hdl/srs_stb.sv
// status byte builder: summaries and master summary
`default_nettype none
module srs_stb
  import srs_pkg::*;
(
  input  wire logic [7:0] esr_i,
  input  wire logic [7:0] ese_i,
  input  wire logic [7:0] sre_i,
  input  wire srs_sum_t   sum_i,
  output logic      [7:0] stb_o,
  output logic            mss_o
);
  logic [7:0] base;

  always_comb begin
    base           = 8'h00;
    base[STB_ERRQ] = sum_i.errq;
    base[STB_QUES] = sum_i.ques;
    base[STB_MAV]  = sum_i.mav;
    base[STB_ESB]  = |(esr_i & ese_i);
    // bit 6 is masked out so the summary never feeds itself
    mss_o          = |(base & sre_i);
    stb_o          = base;
    stb_o[STB_MSS] = mss_o;
  end
endmodule // srs_stb
`default_nettype wire

// File: hdl/srs_status.sv
// status reporting core behind the common status commands
//
// Decided for this implementation: the APB interface to the registers and the address map.
`default_nettype none
module srs_status
  import srs_pkg::*;
(
  input  wire logic        CLOCK_I,
  input  wire logic        SYS_RST_I,
  // apb slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // instrument side
  input  wire logic [7:0]  EVENT_I,
  input  wire srs_sum_t    SUM_I,
  input  wire logic        PENDING_I,
  output srs_reply_t       REPLY_O,
  input  wire logic        REPLY_READY_I,
  output logic             CLEAR_EVENTS_O,
  output logic      [7:0]  STATUS_BYTE_O,
  output logic             SRQ_O,
  output logic             IRQ_O
);
  // ==========================================================================
  // state
  srs_state_t s_r;
  srs_state_t s_nxt;

  logic [7:0]       stb;
  logic             mss;
  logic             setup;
  logic             access;
  logic             cmd_wr;
  logic             is_query;
  logic             stall;
  logic             do_cmd;
  srs_op_t          op;
  logic [ARG_W-1:0] arg;
  logic             arg_bad;
  logic             opc_fire;
  logic             opcq_fire;
  logic [7:0]       ev;
  logic [IRQ_W-1:0] irq_ev;

  srs_stb u_stb (
    .esr_i (s_r.esr),
    .ese_i (s_r.ese),
    .sre_i (s_r.sre),
    .sum_i (SUM_I),
    .stb_o (stb),
    .mss_o (mss)
  );

  function automatic logic op_is_query(input srs_op_t o);
    return (o == OP_SRE_Q) || (o == OP_STB_Q) || (o == OP_ESE_Q) ||
           (o == OP_ESR_Q) || (o == OP_OPC_Q);
  endfunction

  // ==========================================================================
  // bus decode
  always_comb begin
    setup    = PSEL_I && !PENABLE_I;
    access   = PSEL_I && PENABLE_I;
    cmd_wr   = access && PWRITE_I && (PADDR_I == REG_CMD);
    op       = srs_op_t'(PWDATA_I[OP_LSB +: OP_W]);
    arg      = PWDATA_I[ARG_LSB +: ARG_W];
    arg_bad  = |arg[ARG_W-1:8];
    is_query = op_is_query(op);
    // a query waits while the reply slot is full or an opc query is parked,
    // so replies leave in command order
    stall    = cmd_wr && is_query && (s_r.reply.vld || s_r.opcq_pend);
    do_cmd   = cmd_wr && !stall;
  end

  // ==========================================================================
  // next state
  always_comb begin
    s_nxt           = s_r;
    s_nxt.cls_pulse = 1'b0;
    opc_fire        = 1'b0;
    opcq_fire       = 1'b0;
    ev              = EVENT_I;
    irq_ev          = '0;

    if (s_r.reply.vld && REPLY_READY_I) begin
      s_nxt.reply.vld = 1'b0;
    end

    // deferred completion waits for the pending work to drain
    if (s_r.opc_pend && !PENDING_I) begin
      s_nxt.opc_pend = 1'b0;
      opc_fire       = 1'b1;
      ev[ESR_OPC]    = 1'b1;
    end
    if (s_r.opcq_pend && !PENDING_I && !s_r.reply.vld) begin
      s_nxt.opcq_pend  = 1'b0;
      opcq_fire        = 1'b1;
      s_nxt.reply.vld  = 1'b1;
      s_nxt.reply.data = OPC_REPLY;
    end

    if (do_cmd) begin
      unique case (op)
        OP_SRE: begin
          if (arg_bad) begin
            ev[ESR_EXE]     = 1'b1;
            irq_ev[IRQ_RNG] = 1'b1;
          end else begin
            s_nxt.sre = arg[7:0];
          end
        end
        OP_ESE: begin
          if (arg_bad) begin
            ev[ESR_EXE]     = 1'b1;
            irq_ev[IRQ_RNG] = 1'b1;
          end else begin
            s_nxt.ese = arg[7:0];
          end
        end
        OP_SRE_Q: begin
          s_nxt.reply = '{vld: 1'b1, data: s_r.sre};
        end
        OP_STB_Q: begin
          // same byte as the serial poll port, nothing is cleared
          s_nxt.reply = '{vld: 1'b1, data: stb};
        end
        OP_ESE_Q: begin
          s_nxt.reply = '{vld: 1'b1, data: s_r.ese};
        end
        OP_ESR_Q: begin
          s_nxt.reply = '{vld: 1'b1, data: s_r.esr};
          s_nxt.esr   = REG_RESET;
        end
        OP_CLS: begin
          s_nxt.esr       = REG_RESET;
          s_nxt.cls_pulse = 1'b1;
          s_nxt.opc_pend  = 1'b0;
        end
        OP_OPC: begin
          s_nxt.opc_pend = 1'b1;
        end
        OP_OPC_Q: begin
          s_nxt.opcq_pend = 1'b1;
        end
        default: begin
        end
      endcase
    end

    // new events are merged after any clear, so a set wins over a clear;
    // only enabled and implemented bits can latch
    s_nxt.esr = s_nxt.esr | (ev & s_r.ese & ESR_USED);

    // interrupt: sticky status, write one to clear, set wins
    s_nxt.mss_q = mss;
    irq_ev[IRQ_SRQ] = mss && !s_r.mss_q;
    irq_ev[IRQ_OPC] = opc_fire || opcq_fire;
    if (access && PWRITE_I && (PADDR_I == REG_IRQ_STAT)) begin
      s_nxt.irq_stat = s_r.irq_stat & ~PWDATA_I[IRQ_W-1:0];
    end
    if (access && PWRITE_I && (PADDR_I == REG_IRQ_MASK)) begin
      s_nxt.irq_mask = PWDATA_I[IRQ_W-1:0];
    end
    s_nxt.irq_stat = s_nxt.irq_stat | irq_ev;

    // read data and error captured in the setup cycle
    if (setup) begin
      s_nxt.prdata  = '0;
      s_nxt.pslverr = 1'b0;
      unique case (PADDR_I)
        REG_CMD:      s_nxt.prdata = '0;
        REG_REPLY:    s_nxt.prdata = {23'h0, s_r.reply.vld, s_r.reply.data};
        REG_SRE:      s_nxt.prdata = {24'h0, s_r.sre};
        REG_ESE:      s_nxt.prdata = {24'h0, s_r.ese};
        REG_ESR:      s_nxt.prdata = {24'h0, s_r.esr};
        REG_STB:      s_nxt.prdata = {24'h0, stb};
        REG_IRQ_STAT: s_nxt.prdata = {29'h0, s_r.irq_stat};
        REG_IRQ_MASK: s_nxt.prdata = {29'h0, s_r.irq_mask};
        default:      s_nxt.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // outputs
  assign PRDATA_O       = s_r.prdata;
  assign PREADY_O       = !stall;
  assign PSLVERR_O      = access && s_r.pslverr;
  assign REPLY_O        = s_r.reply;
  assign CLEAR_EVENTS_O = s_r.cls_pulse;
  assign STATUS_BYTE_O  = stb;
  assign SRQ_O          = mss;
  assign IRQ_O          = |(s_r.irq_stat & s_r.irq_mask);

  // ==========================================================================
  // assertions
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);

  a_sre_load: assert property (
    do_cmd && op == OP_SRE && !arg_bad |=> s_r.sre == $past(arg[7:0]))
    else $error("sre not loaded");
  a_range_keep: assert property (
    do_cmd && (op == OP_SRE || op == OP_ESE) && arg_bad
    |=> $stable(s_r.sre) && $stable(s_r.ese)
        && (s_r.esr[ESR_EXE] || !$past(s_r.ese[ESR_EXE])))
    else $error("bad argument changed enable");
  a_sre_query: assert property (
    do_cmd && op == OP_SRE_Q
    |=> REPLY_O.vld && REPLY_O.data == $past(s_r.sre) && $stable(s_r.sre))
    else $error("sre query wrong");
  a_stb_query: assert property (
    do_cmd && op == OP_STB_Q |=> REPLY_O.data == $past(STATUS_BYTE_O)
      && (SRQ_O || !$past(SRQ_O) || $past(SUM_I) != SUM_I
          || $past(s_r.esr) != s_r.esr))
    else $error("stb query wrong");
  a_mss_sum: assert property (
    STATUS_BYTE_O[STB_MSS] == |(STATUS_BYTE_O & s_r.sre & 8'hbf)
    && STATUS_BYTE_O[7] == 1'b0 && STATUS_BYTE_O[1:0] == 2'b00)
    else $error("master summary wrong");
  a_ese_query: assert property (
    do_cmd && op == OP_ESE_Q |=> REPLY_O.data == $past(s_r.ese))
    else $error("ese query wrong");
  a_esr_query: assert property (
    do_cmd && op == OP_ESR_Q
    |=> REPLY_O.data == $past(s_r.esr)
        && (s_r.esr & ~$past(EVENT_I | 8'h11)) == 8'h00)
    else $error("esr query wrong");
  a_cls_clear: assert property (
    do_cmd && op == OP_CLS
    |=> CLEAR_EVENTS_O && (s_r.esr & ~$past(EVENT_I | 8'h11)) == 8'h00
        && $stable(s_r.ese) && $stable(s_r.sre) ##1 !CLEAR_EVENTS_O)
    else $error("clear status wrong");
  a_opc_wait: assert property (
    s_r.opc_pend && PENDING_I && !EVENT_I[ESR_OPC] && !s_r.esr[ESR_OPC]
    |=> !s_r.esr[ESR_OPC])
    else $error("opc set early");
  a_opcq_wait: assert property (
    s_r.opcq_pend && PENDING_I |=> !(REPLY_O.vld && !$past(REPLY_O.vld)))
    else $error("opc reply early");
  a_enable_gate: assert property (
    (s_r.esr & ~$past(s_r.esr) & ~$past(s_r.ese)) == 8'h00
    && (s_r.esr & ~ESR_USED) == 8'h00)
    else $error("event latched while disabled");
endmodule // srs_status
`default_nettype wire

// File: dv/srs_queue_model.sv
// output queue model: takes replies from the block with random stalls
`default_nettype none
module srs_queue_model
  import srs_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire srs_reply_t reply_i,
  output logic            ready_o,
  output logic [7:0]      last_o,
  output int              count_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = 18;
  // ==========================================================================
  // stalls force the block to hold vld across refused cycles
  always @(posedge clk_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
      count_o <= 0;
    end else begin
      if (reply_i.vld && ready_o) begin
        last_o  <= reply_i.data;
        count_o <= count_o + 1;
      end
      ready_o <= 1'($random(seed));
    end
  end
endmodule // srs_queue_model
`default_nettype wire

// File: dv/srs_status_tb.sv
// self-checking bench for the status reporting block
`default_nettype none
module srs_status_tb
  import srs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic        pend = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  ev = 8'h00;
  srs_sum_t    sum = '0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic        rdy;
  logic        clr;
  logic        srq;
  logic        irq;
  srs_reply_t  reply;
  logic [7:0]  stb;
  logic [7:0]  qd;
  logic [7:0]  sre_v;
  logic [7:0]  ese_v;
  logic [7:0]  esr_v;
  logic [7:0]  e;
  int          qn;
  int          n0;
  int          seed = 18;
  int          num_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          clr_n = 0;

  srs_status uut (.CLOCK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .EVENT_I(ev), .SUM_I(sum), .PENDING_I(pend), .REPLY_O(reply),
    .REPLY_READY_I(rdy), .CLEAR_EVENTS_O(clr), .STATUS_BYTE_O(stb),
    .SRQ_O(srq), .IRQ_O(irq));
  srs_queue_model q_model (.clk_i(clk), .rst_i(rst), .reply_i(reply),
    .ready_o(rdy), .last_o(qd), .count_o(qn));

  initial forever #2 clk = ~clk;
  // ==========================================================================
  // cycle ceiling and pulse counter
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (clr === 1'b1) clr_n = clr_n + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      give_verdict();
    end
  end

  // ==========================================================================
  // tasks and expectations
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // the request stands until pready is seen high at a rising edge; an idle
  // cycle follows so the next call never rewrites psel in the same step
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 32'h0);
    chk(rd, {24'h0, x});
  endtask

  task automatic cmd(input srs_op_t op, input logic [15:0] arg);
    apb(1'b1, REG_CMD, {8'h00, arg, 4'h0, op});
  endtask

  // with hold set the reply must stay away while work is pending
  task automatic query(input srs_op_t op, input logic [7:0] x,
                       input logic hold);
    int k;
    n0 = qn;
    cmd(op, 16'h0000);
    if (hold) begin
      repeat (20) @(posedge clk);
      chk(32'(qn - n0), 32'h0);
      pend <= 1'b0;
    end
    k = 0;
    while (qn == n0 && k < 200) begin
      @(posedge clk);
      k = k + 1;
    end
    chk({24'h0, qd}, {24'h0, x});
  endtask

  function automatic logic [7:0] stb_f(input logic [7:0] r,
      input logic [7:0] en, input logic [7:0] sr, input srs_sum_t s);
    logic [7:0] b;
    b    = {2'b00, |(r & en), s.mav, s.ques, s.errq, 2'b00};
    b[6] = |(b & sr);
    return b;
  endfunction

  // ==========================================================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 8; i++) rdchk(8'(4 * i), 8'h00);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    repeat (6) begin
      sre_v = 8'($random(seed));
      ese_v = 8'($random(seed));
      cmd(OP_SRE, {8'h00, sre_v});
      cmd(OP_ESE, {8'h00, ese_v});
      query(OP_SRE_Q, sre_v, 1'b0);
      query(OP_SRE_Q, sre_v, 1'b0);
      query(OP_ESE_Q, ese_v, 1'b0);
      e = 8'($random(seed));
      ev <= e;
      @(posedge clk);
      ev <= 8'h00;
      sum <= 3'($random(seed));
      esr_v = e & ese_v & ESR_USED;
      rdchk(REG_ESR, esr_v);
      e = stb_f(esr_v, ese_v, sre_v, sum);
      chk({24'h0, stb}, {24'h0, e});
      chk({31'h0, srq}, {31'h0, e[6]});
      rdchk(REG_STB, e);
      query(OP_STB_Q, e, 1'b0);
      chk({31'h0, stb[6]}, {31'h0, e[6]});
      query(OP_ESR_Q, esr_v, 1'b0);
      query(OP_ESR_Q, 8'h00, 1'b0);
    end
    cmd(OP_ESE, 16'h00ff);
    apb(1'b1, REG_IRQ_MASK, 32'h2);
    rdchk(REG_IRQ_MASK, 8'h02);
    cmd(OP_SRE, {8'h01, ~sre_v});
    rdchk(REG_SRE, sre_v);
    rdchk(REG_ESR, 8'h10);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, REG_IRQ_STAT, 32'h7);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, REG_IRQ_MASK, 32'h0);
    cmd(OP_ESE, 16'h8000);
    rdchk(REG_ESE, 8'hff);
    apb(1'b0, REG_IRQ_STAT, 32'h0);
    chk({31'h0, rd[IRQ_RNG]}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    n0 = clr_n;
    cmd(OP_CLS, 16'h0000);
    repeat (2) @(posedge clk);
    chk(32'(clr_n - n0), 32'h1);
    rdchk(REG_ESR, 8'h00);
    chk({31'h0, stb[STB_ESB]}, 32'h0);
    rdchk(REG_ESE, 8'hff);
    rdchk(REG_SRE, sre_v);
    pend <= 1'b1;
    cmd(OP_OPC, 16'h0000);
    repeat (20) @(posedge clk);
    rdchk(REG_ESR, 8'h00);
    pend <= 1'b0;
    repeat (3) @(posedge clk);
    rdchk(REG_ESR, 8'h01);
    pend <= 1'b1;
    query(OP_OPC_Q, OPC_REPLY, 1'b1);
    // back to back queries: the second may wait on a full reply slot
    n0 = qn;
    cmd(OP_SRE_Q, 16'h0000);
    cmd(OP_ESE_Q, 16'h0000);
    while (qn - n0 < 2) @(posedge clk);
    chk({24'h0, qd}, {24'h0, 8'hff});
    give_verdict();
  end
endmodule // srs_status_tb
`default_nettype wire
